// ### core/tma_pkg.sv
// Constants, word layouts and entry types for the translation buffer array access port.
package tma_pkg;

    localparam logic [7:0] CODE_IADDR = 8'hf2;
    localparam logic [8:0] CODE_IDAT1 = 9'h1e6;
    localparam logic [8:0] CODE_IDAT2 = 9'h1e7;
    localparam logic [7:0] CODE_UADDR = 8'hf6;
    localparam logic [8:0] CODE_UDAT1 = 9'h1ee;
    localparam logic [8:0] CODE_UDAT2 = 9'h1ef;
    localparam int IDX_LSB = 8;
    localparam int ASSOC_BIT = 7;
    localparam logic [31:0] ADDR_ADDRESS_SPACE_ID = 32'hff00_0000;
    localparam logic [31:0] ADDR_STAT = 32'hff00_0004;
    localparam logic [3:0] STRB_FULL = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [21:0] MASK_1K = 22'h3fffff;
    localparam logic [21:0] MASK_4K = 22'h3ffffc;
    localparam logic [21:0] MASK_64K = 22'h3fffc0;
    localparam logic [21:0] MASK_1M = 22'h3ffc00;

    typedef enum logic [3:0] {
        RG_NONE, RG_IADDR, RG_IDAT1, RG_IDAT2, RG_UADDR, RG_UDAT1, RG_UDAT2, RG_ADDRESS_SPACE_ID, RG_STAT
    } tma_region_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } tma_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tma_axi_rsp_t;

    typedef struct packed {
        logic [21:0] virtual_page_number;
        logic dirty;
        logic valid;
        logic [7:0] address_space_id;
    } tma_addr_word_t;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic [18:0] physical_page_number;
        logic rsv_9;
        logic valid;
        logic size_hi;
        logic [1:0] protection_field;
        logic size_lo;
        logic cacheable;
        logic dirty;
        logic shared_flag;
        logic write_through_flag;
    } tma_data1_word_t;

    typedef struct packed {
        logic [27:0] rsv;
        logic timing_control_flag;
        logic [2:0] space_attribute;
    } tma_data2_word_t;

    typedef struct packed {
        logic [30:0] rsv;
        logic mhit_seen;
    } tma_stat_word_t;

    typedef struct packed {
        logic [21:0] virtual_page_number;
        logic [7:0] address_space_id;
        logic valid;
        logic [18:0] physical_page_number;
        logic [1:0] page_size_field;
        logic protection_field;
        logic cacheable;
        logic shared_flag;
        logic [2:0] space_attribute;
        logic timing_control_flag;
    } tma_ient_t;

    typedef struct packed {
        logic [21:0] virtual_page_number;
        logic [7:0] address_space_id;
        logic valid;
        logic dirty;
        logic [18:0] physical_page_number;
        logic [1:0] page_size_field;
        logic [1:0] protection_field;
        logic cacheable;
        logic shared_flag;
        logic write_through_flag;
        logic [2:0] space_attribute;
        logic timing_control_flag;
    } tma_uent_t;

    function automatic tma_region_t tma_decode(input logic [31:0] a);
        tma_region_t r;
        r = RG_NONE;
        if (a == ADDR_ADDRESS_SPACE_ID) begin
            r = RG_ADDRESS_SPACE_ID;
        end else if (a == ADDR_STAT) begin
            r = RG_STAT;
        end else if (a[31:24] == CODE_IADDR) begin
            r = RG_IADDR;
        end else if (a[31:23] == CODE_IDAT1) begin
            r = RG_IDAT1;
        end else if (a[31:23] == CODE_IDAT2) begin
            r = RG_IDAT2;
        end else if (a[31:24] == CODE_UADDR) begin
            r = RG_UADDR;
        end else if (a[31:23] == CODE_UDAT1) begin
            r = RG_UDAT1;
        end else if (a[31:23] == CODE_UDAT2) begin
            r = RG_UDAT2;
        end
        return r;
    endfunction

    function automatic logic tma_vpn_hit(input logic [21:0] ev, input logic [1:0] sz, input logic [21:0] v);
        logic [21:0] m;
        unique case (sz)
            2'h0: m = MASK_1K;
            2'h1: m = MASK_4K;
            2'h2: m = MASK_64K;
            2'h3: m = MASK_1M;
        endcase
        return ((ev ^ v) & m) == '0;
    endfunction

endpackage

// ### core/tma_top.sv
// Memory-mapped access port to the instruction and unified translation buffer arrays.
//
// Notes on behaviour
// - Code f2 selects instruction address array, index 9:8.
// - Instruction address array reads/writes page, valid, id.
// - Address selects entry; writes also carry data.
// - Code f30 selects instruction data array one.
// - Instruction data one word field layout.
// - Instruction data one reads/writes its fields.
// - Code f38 selects instruction data array two.
// - Data two: attribute bits 2:0, timing bit 3.
// - Code f6 selects unified address array, index 13:8.
// - Address bit 7 selects associative write.
// - Unified address word: page, dirty, valid, id.
// - Unified address reads never compare associatively.
// - Direct write stores page, dirty, valid, id.
// - Associative write compares all entries with current id unless shared.
// - No unified match means no unified entry write, no exception.
// - Single unified match updates dirty and valid only.
// - Several unified matches raise multiple-hit exception.
// - Instruction buffer compares too, valid written on match.
// - Match in both also writes instruction entry.
// - Code f70 selects unified data array one.
// - Unified data one word field layout.
// - Code f78 selects unified data array two.
// - Unified data two: timing bit 3, attribute 2:0.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module tma_top
    import tma_pkg::*;
#(
    parameter int IT_N = 4,
    parameter int UT_N = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tma_axi_req_t axi_req,
    output tma_axi_rsp_t axi_rsp,
    output logic mhit_exc
);

    localparam int IT_IW = $clog2(IT_N);
    localparam int UT_IW = $clog2(UT_N);

    typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_RD, ST_BRESP, ST_RRESP} tma_state_t;

    typedef struct packed {
        tma_state_t st;
        logic aw_got;
        logic w_got;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] raddr;
        tma_axi_rsp_t rsp;
        logic mhit;
        logic mhit_seen;
        logic [7:0] cur_address_space_id;
        tma_ient_t [IT_N-1:0] it;
        tma_uent_t [UT_N-1:0] ut;
    } tma_all_t;

    tma_all_t s_r;
    tma_all_t s_nxt;
    tma_region_t w_rg;
    tma_region_t r_rg;
    logic [IT_IW-1:0] w_it;
    logic [UT_IW-1:0] w_ut;
    logic [IT_IW-1:0] r_it;
    logic [UT_IW-1:0] r_ut;
    tma_addr_word_t w_aw;
    tma_data1_word_t w_d1;
    tma_data2_word_t w_d2;
    tma_stat_word_t w_st;
    logic [IT_N-1:0] it_hit;
    logic [UT_N-1:0] ut_hit;
    logic ut_any;
    logic ut_many;

    // Decode keeps only the region code and the index field; the id and status registers match the whole address.
    assign w_rg = tma_decode(s_r.waddr);
    assign r_rg = tma_decode(s_r.raddr);
    assign w_it = s_r.waddr[IDX_LSB +: IT_IW];
    assign w_ut = s_r.waddr[IDX_LSB +: UT_IW];
    assign r_it = s_r.raddr[IDX_LSB +: IT_IW];
    assign r_ut = s_r.raddr[IDX_LSB +: UT_IW];
    assign w_aw = tma_addr_word_t'(s_r.wdata);
    assign w_d1 = tma_data1_word_t'(s_r.wdata);
    assign w_d2 = tma_data2_word_t'(s_r.wdata);
    assign w_st = tma_stat_word_t'(s_r.wdata);

    // Each entry compares page number by its size and the current id unless shared.
    for (genvar g = 0; g < UT_N; g++) begin : g_ut
        assign ut_hit[g] = s_r.ut[g].valid
            && tma_vpn_hit(s_r.ut[g].virtual_page_number, s_r.ut[g].page_size_field, w_aw.virtual_page_number)
            && (s_r.ut[g].shared_flag || s_r.ut[g].address_space_id == s_r.cur_address_space_id);
    end
    for (genvar g = 0; g < IT_N; g++) begin : g_it
        assign it_hit[g] = s_r.it[g].valid
            && tma_vpn_hit(s_r.it[g].virtual_page_number, s_r.it[g].page_size_field, w_aw.virtual_page_number)
            && (s_r.it[g].shared_flag || s_r.it[g].address_space_id == s_r.cur_address_space_id);
    end

    always_comb begin
        ut_any = 1'b0;
        ut_many = 1'b0;
        for (int i = 0; i < UT_N; i++) begin
            if (ut_hit[i] && ut_any) begin
                ut_many = 1'b1;
            end
            if (ut_hit[i]) begin
                ut_any = 1'b1;
            end
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.mhit = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (axi_req.awvalid && s_r.rsp.awready) begin
                    s_nxt.aw_got = 1'b1;
                    s_nxt.waddr = axi_req.awaddr;
                end
                if (axi_req.wvalid && s_r.rsp.wready) begin
                    s_nxt.w_got = 1'b1;
                    s_nxt.wdata = axi_req.wdata;
                    s_nxt.wstrb = axi_req.wstrb;
                end
                if (axi_req.arvalid && s_r.rsp.arready) begin
                    s_nxt.raddr = axi_req.araddr;
                    s_nxt.st = ST_RD;
                end else if (s_nxt.aw_got && s_nxt.w_got) begin
                    s_nxt.st = ST_WR;
                end
            end
            ST_WR: begin
                s_nxt.aw_got = 1'b0;
                s_nxt.w_got = 1'b0;
                s_nxt.rsp.bvalid = 1'b1;
                s_nxt.rsp.bresp = RESP_OKAY;
                s_nxt.st = ST_BRESP;
                if (s_r.wstrb != STRB_FULL) begin
                    s_nxt.rsp.bresp = RESP_SLVERR;
                end else begin
                    unique case (w_rg)
                        RG_IADDR: begin
                            s_nxt.it[w_it].virtual_page_number = w_aw.virtual_page_number;
                            s_nxt.it[w_it].valid = w_aw.valid;
                            s_nxt.it[w_it].address_space_id = w_aw.address_space_id;
                        end
                        RG_IDAT1: begin
                            s_nxt.it[w_it].physical_page_number = w_d1.physical_page_number;
                            s_nxt.it[w_it].valid = w_d1.valid;
                            s_nxt.it[w_it].page_size_field = {w_d1.size_hi, w_d1.size_lo};
                            s_nxt.it[w_it].protection_field = w_d1.protection_field[1];
                            s_nxt.it[w_it].cacheable = w_d1.cacheable;
                            s_nxt.it[w_it].shared_flag = w_d1.shared_flag;
                        end
                        RG_IDAT2: begin
                            s_nxt.it[w_it].space_attribute = w_d2.space_attribute;
                            s_nxt.it[w_it].timing_control_flag = w_d2.timing_control_flag;
                        end
                        RG_UADDR: begin
                            if (!s_r.waddr[ASSOC_BIT]) begin
                                s_nxt.ut[w_ut].virtual_page_number = w_aw.virtual_page_number;
                                s_nxt.ut[w_ut].dirty = w_aw.dirty;
                                s_nxt.ut[w_ut].valid = w_aw.valid;
                                s_nxt.ut[w_ut].address_space_id = w_aw.address_space_id;
                            end else begin
                                for (int i = 0; i < IT_N; i++) begin
                                    if (it_hit[i]) begin
                                        s_nxt.it[i].valid = w_aw.valid;
                                    end
                                end
                                if (ut_many) begin
                                    s_nxt.mhit = 1'b1;
                                    s_nxt.mhit_seen = 1'b1;
                                end else begin
                                    for (int i = 0; i < UT_N; i++) begin
                                        if (ut_hit[i]) begin
                                            s_nxt.ut[i].dirty = w_aw.dirty;
                                            s_nxt.ut[i].valid = w_aw.valid;
                                        end
                                    end
                                end
                            end
                        end
                        RG_UDAT1: begin
                            s_nxt.ut[w_ut].physical_page_number = w_d1.physical_page_number;
                            s_nxt.ut[w_ut].valid = w_d1.valid;
                            s_nxt.ut[w_ut].page_size_field = {w_d1.size_hi, w_d1.size_lo};
                            s_nxt.ut[w_ut].protection_field = w_d1.protection_field;
                            s_nxt.ut[w_ut].cacheable = w_d1.cacheable;
                            s_nxt.ut[w_ut].dirty = w_d1.dirty;
                            s_nxt.ut[w_ut].shared_flag = w_d1.shared_flag;
                            s_nxt.ut[w_ut].write_through_flag = w_d1.write_through_flag;
                        end
                        RG_UDAT2: begin
                            s_nxt.ut[w_ut].space_attribute = w_d2.space_attribute;
                            s_nxt.ut[w_ut].timing_control_flag = w_d2.timing_control_flag;
                        end
                        RG_ADDRESS_SPACE_ID: begin
                            s_nxt.cur_address_space_id = w_aw.address_space_id;
                        end
                        RG_STAT: begin
                            if (w_st.mhit_seen) begin
                                s_nxt.mhit_seen = 1'b0;
                            end
                        end
                        RG_NONE: begin
                            s_nxt.rsp.bresp = RESP_DECERR;
                        end
                    endcase
                end
            end
            ST_RD: begin
                s_nxt.rsp.rvalid = 1'b1;
                s_nxt.rsp.rresp = RESP_OKAY;
                s_nxt.rsp.rdata = '0;
                s_nxt.st = ST_RRESP;
                unique case (r_rg)
                    RG_IADDR: begin
                        s_nxt.rsp.rdata = tma_addr_word_t'{
                            virtual_page_number: s_r.it[r_it].virtual_page_number, dirty: 1'b0,
                            valid: s_r.it[r_it].valid, address_space_id: s_r.it[r_it].address_space_id};
                    end
                    RG_IDAT1: begin
                        s_nxt.rsp.rdata = tma_data1_word_t'{
                            physical_page_number: s_r.it[r_it].physical_page_number,
                            valid: s_r.it[r_it].valid, size_hi: s_r.it[r_it].page_size_field[1],
                            protection_field: {s_r.it[r_it].protection_field, 1'b0},
                            size_lo: s_r.it[r_it].page_size_field[0], cacheable: s_r.it[r_it].cacheable,
                            shared_flag: s_r.it[r_it].shared_flag, default: '0};
                    end
                    RG_IDAT2: begin
                        s_nxt.rsp.rdata = tma_data2_word_t'{
                            rsv: '0, timing_control_flag: s_r.it[r_it].timing_control_flag,
                            space_attribute: s_r.it[r_it].space_attribute};
                    end
                    RG_UADDR: begin
                        s_nxt.rsp.rdata = tma_addr_word_t'{
                            virtual_page_number: s_r.ut[r_ut].virtual_page_number, dirty: s_r.ut[r_ut].dirty,
                            valid: s_r.ut[r_ut].valid, address_space_id: s_r.ut[r_ut].address_space_id};
                    end
                    RG_UDAT1: begin
                        s_nxt.rsp.rdata = tma_data1_word_t'{
                            physical_page_number: s_r.ut[r_ut].physical_page_number,
                            valid: s_r.ut[r_ut].valid, size_hi: s_r.ut[r_ut].page_size_field[1],
                            protection_field: s_r.ut[r_ut].protection_field,
                            size_lo: s_r.ut[r_ut].page_size_field[0], cacheable: s_r.ut[r_ut].cacheable,
                            dirty: s_r.ut[r_ut].dirty, shared_flag: s_r.ut[r_ut].shared_flag,
                            write_through_flag: s_r.ut[r_ut].write_through_flag, default: '0};
                    end
                    RG_UDAT2: begin
                        s_nxt.rsp.rdata = tma_data2_word_t'{
                            rsv: '0, timing_control_flag: s_r.ut[r_ut].timing_control_flag,
                            space_attribute: s_r.ut[r_ut].space_attribute};
                    end
                    RG_ADDRESS_SPACE_ID: begin
                        s_nxt.rsp.rdata = {24'h00_0000, s_r.cur_address_space_id};
                    end
                    RG_STAT: begin
                        s_nxt.rsp.rdata = tma_stat_word_t'{rsv: '0, mhit_seen: s_r.mhit_seen};
                    end
                    RG_NONE: begin
                        s_nxt.rsp.rresp = RESP_DECERR;
                    end
                endcase
            end
            ST_BRESP: begin
                if (axi_req.bready) begin
                    s_nxt.rsp.bvalid = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_RRESP: begin
                if (axi_req.rready) begin
                    s_nxt.rsp.rvalid = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
        endcase
        // Readies are offered only while idle, reads only with no write half taken.
        if (s_nxt.st == ST_IDLE) begin
            s_nxt.rsp.awready = !s_nxt.aw_got;
            s_nxt.rsp.wready = !s_nxt.w_got;
            s_nxt.rsp.arready = !s_nxt.aw_got && !s_nxt.w_got;
        end else begin
            s_nxt.rsp.awready = 1'b0;
            s_nxt.rsp.wready = 1'b0;
            s_nxt.rsp.arready = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axi_rsp = s_r.rsp;
    assign mhit_exc = s_r.mhit;

endmodule

// ### verif/tma_top_assertions.sv
// Concurrent checks on the bus and exception ports of the array access port.
`timescale 1ns/1ps

module tma_top_assertions
    import tma_pkg::*;
#(
    parameter int IT_N = 4,
    parameter int UT_N = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tma_axi_req_t axi_req,
    input wire tma_axi_rsp_t axi_rsp,
    input wire logic mhit_exc
);
    logic wr_take;
    logic rd_take;
    logic assoc_take;
    assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    assign rd_take = axi_req.arvalid && axi_rsp.arready;
    assign assoc_take = wr_take && axi_req.awaddr[31:24] == CODE_UADDR && axi_req.awaddr[ASSOC_BIT];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_answer;
        ##1 !axi_rsp.bvalid ##1 axi_rsp.bvalid;
    endsequence
    sequence s_rd_answer;
        ##1 !axi_rsp.rvalid ##1 axi_rsp.rvalid;
    endsequence

    a_wr_latency: assert property (wr_take && !rd_take |-> s_wr_answer)
        else $error("write answer not two edges after acceptance");
    a_rd_latency: assert property (rd_take |-> s_rd_answer)
        else $error("read answer not two edges after acceptance");
    a_b_single: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response repeated");
    a_r_single: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
        else $error("read response repeated or port not idle");
    a_busy_block: assert property (axi_rsp.bvalid || axi_rsp.rvalid |->
        !axi_rsp.arready && !axi_rsp.awready && !axi_rsp.wready)
        else $error("request accepted while a response is pending");
    a_mhit_pulse: assert property (mhit_exc |-> $rose(axi_rsp.bvalid) ##1 !mhit_exc)
        else $error("multiple hit not a single pulse with the response");
    a_mhit_cause: assert property (mhit_exc |-> $past(assoc_take, 2))
        else $error("multiple hit without an associative write");
    a_unmap_decerr: assert property (rd_take && axi_req.araddr[31:28] != 4'h0f |->
        ##2 axi_rsp.rresp == RESP_DECERR && axi_rsp.rdata == '0)
        else $error("unmapped read not refused");
    a_strb_refuse: assert property (wr_take && axi_req.wstrb != STRB_FULL |->
        ##2 axi_rsp.bresp == RESP_SLVERR && !mhit_exc)
        else $error("partial write not refused");
    a_data2_layout: assert property (rd_take &&
        (axi_req.araddr[31:23] == CODE_IDAT2 || axi_req.araddr[31:23] == CODE_UDAT2) |->
        ##2 axi_rsp.rdata[31:4] == '0)
        else $error("data two word has bits above timing flag");
endmodule

// ### verif/tma_cpu_model.sv
// Behavioural load and store master that issues longword accesses to the array port.
`timescale 1ns/1ps

module tma_cpu_model
    import tma_pkg::*;
(
    input wire logic aclk,
    input wire tma_axi_rsp_t rsp,
    input wire logic mhit_exc,
    output tma_axi_req_t req,
    output logic hung,
    output logic mhit_seen
);
    initial begin
        req = '0;
        hung = 1'b0;
        mhit_seen = 1'b0;
    end

    // Released lines show inverted values, so a late sample of address or data shows up.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic busy;
        busy = 1'b1;
        r = 2'h1;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (int n = 0; n < 100 && busy; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) begin
                req.awvalid <= 1'b0;
                req.awaddr <= ~a;
            end
            if (req.wvalid && rsp.wready) begin
                req.wvalid <= 1'b0;
                req.wdata <= ~d;
            end
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                r = rsp.bresp;
                mhit_seen = mhit_exc;
                busy = 1'b0;
            end
        end
        hung = busy;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic busy;
        busy = 1'b1;
        r = 2'h1;
        d = '0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (int n = 0; n < 100 && busy; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) begin
                req.arvalid <= 1'b0;
                req.araddr <= ~a;
            end
            if (rsp.rvalid) begin
                req.rready <= 1'b0;
                d = rsp.rdata;
                r = rsp.rresp;
                busy = 1'b0;
            end
        end
        hung = busy;
    endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the translation buffer array access port.
`timescale 1ns/1ps

module tb;
    import tma_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    tma_axi_req_t axi_req;
    tma_axi_rsp_t axi_rsp;
    logic mhit_exc;
    logic hung;
    logic mhit_seen;
    logic [31:0] rd_data;
    logic [1:0] resp;
    int errors = 0;
    int total_checks = 0;

    always #10 aclk = ~aclk;

    tma_top i_tma_top (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .mhit_exc(mhit_exc));
    tma_cpu_model u_cpu (.aclk(aclk), .rsp(axi_rsp), .mhit_exc(mhit_exc), .req(axi_req), .hung(hung),
        .mhit_seen(mhit_seen));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic guard();
        if (hung) begin
            errors++;
            $display("ERROR %0t: bus answer timed out", $time);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_cpu.wr(a, d, STRB_FULL, resp);
        guard();
        check({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        u_cpu.rd(a, rd_data, resp);
        guard();
        check(rd_data, e);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(32'hf200_0300, 32'hffff_fd5a);
        rd_chk(32'hf2ff_f3fc, 32'hffff_fd5a);
        rd_chk(32'hf200_0200, 32'h0000_0000);
        wr(32'hf300_0300, 32'h1234_55da);
        rd_chk(32'hf37f_fffc, 32'h1234_55da);
        wr(32'hf380_0100, 32'h0000_000d);
        rd_chk(32'hf3ff_f1fc, 32'h0000_000d);
        wr(32'hf780_3f00, 32'h0000_000a);
        rd_chk(32'hf7ff_ff00, 32'h0000_000a);
        wr(32'hf700_0500, 32'h0abc_d5ff);
        rd_chk(32'hf77f_c500, 32'h0abc_d5ff);
        wr(32'hf600_0500, 32'h4000_0111);
        rd_chk(32'hf6ff_c580, 32'h4000_0111);
        rd_chk(32'hf700_0500, 32'h0abc_d5fb);
        wr(ADDR_ADDRESS_SPACE_ID, 32'h0000_0011);
        wr(32'hf600_0080, 32'hffff_fc00);
        check({31'h0, mhit_seen}, 32'h0);
        rd_chk(32'hf200_0300, 32'hffff_fc5a);
        rd_chk(32'hf600_0500, 32'h4000_0111);
        wr(32'hf6ff_ff80, 32'h4000_fe00);
        rd_chk(32'hf600_0500, 32'h4000_0211);
        wr(32'hf600_0500, 32'h4000_0111);
        wr(32'hf700_0600, 32'h0abc_d5fb);
        wr(32'hf600_0600, 32'h4000_0111);
        wr(32'hf600_0080, 32'h4000_0300);
        check({31'h0, mhit_seen}, 32'h1);
        rd_chk(32'hf600_0500, 32'h4000_0111);
        rd_chk(ADDR_STAT, 32'h0000_0001);
        wr(ADDR_STAT, 32'h0000_0001);
        rd_chk(ADDR_STAT, 32'h0000_0000);
        wr(32'hf700_0700, 32'h0abc_d5fb);
        wr(32'hf600_0700, 32'hffff_fd11);
        wr(32'hf200_0300, 32'hffff_fd5a);
        wr(32'hf600_0080, 32'hffff_fe00);
        check({31'h0, mhit_seen}, 32'h0);
        rd_chk(32'hf600_0700, 32'hffff_fe11);
        rd_chk(32'hf700_0700, 32'h0abc_d4ff);
        rd_chk(32'hf200_0300, 32'hffff_fc5a);
        u_cpu.wr(32'hf380_0100, 32'h0000_0005, 4'h3, resp);
        guard();
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd_chk(32'hf380_0100, 32'h0000_000d);
        u_cpu.rd(32'h1000_0000, rd_data, resp);
        guard();
        check({30'h0, resp}, {30'h0, RESP_DECERR});
        check(rd_data, 32'h0000_0000);
        wrap_up();
    end
endmodule

bind tma_top tma_top_assertions #(.IT_N(IT_N), .UT_N(UT_N)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .mhit_exc(mhit_exc));
